// ### hdl/mid_pkg.sv
// shared constants, types and instruction decode for the core
package mid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and sizes
  localparam int IW   = 14;  // instruction word
  localparam int DW   = 8;   // data byte
  localparam int FN   = 128; // file register entries
  localparam int FAW  = 7;   // file register slot width
  localparam int PCW  = 11;  // program counter width
  localparam int PH_N = 4;   // clock periods per instruction cycle
  localparam int AW   = 12;  // apb address width

  ////////////////////////////////////////////////////////////////////////////
  // operand field positions
  localparam int F_LO  = 0;
  localparam int D_POS = 7;
  localparam int B_LO  = 7;
  localparam int K_LO  = 0;

  // opcode values of this core's own encoding
  localparam logic [5:0]    OPC_REG_MINUS = 6'h02;
  localparam logic [5:0]    OPC_XOR_REG   = 6'h06;
  localparam logic [5:0]    OPC_SWAP      = 6'h0e;
  localparam logic [5:0]    OPC_XOR_LIT   = 6'h3a;
  localparam logic [5:0]    OPC_LIT_MINUS = 6'h3c;
  localparam logic [5:0]    OPC_LIT_MASK  = 6'h3e;
  localparam logic [3:0]    OPC_SKIPC     = 4'h6;
  localparam logic [2:0]    OPC_JUMP      = 3'h5;
  localparam logic [IW-1:0] NOP_WORD      = 14'h0000;
  localparam logic [IW-1:0] NOP_MASK      = 14'h3f9f;
  // don't-care bit positions of the literal subtract and of the nop
  localparam logic [IW-1:0] X_LIT         = 14'h0100;
  localparam logic [IW-1:0] X_NOP         = 14'h0060;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets and bit positions
  localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [AW-1:0] ADDR_STAT = 12'h004;
  localparam logic [AW-1:0] ADDR_ACC  = 12'h008;
  localparam logic [AW-1:0] ADDR_PC   = 12'h00c;
  localparam logic [AW-1:0] ADDR_ICNT = 12'h010;
  localparam logic [AW-1:0] PMEM_BASE = 12'h400;
  localparam logic [AW-1:0] FILE_BASE = 12'h800;
  localparam logic [AW-1:0] WIN_MASK  = 12'hc00;
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_RESTART = 1;
  localparam int STAT_C       = 0;
  localparam int STAT_Z       = 2;
  localparam int STAT_BUB     = 3;
  localparam int STAT_RUN     = 4;

  // reset values
  localparam logic [DW-1:0]  RST_ACC = 8'h00;
  localparam logic [PCW-1:0] RST_PC  = 11'h000;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    OP_BAD, OP_NOP, OP_REG_MINUS, OP_XOR_REG, OP_SWAP,
    OP_LIT_MINUS, OP_XOR_LIT, OP_SKIPC, OP_JUMP
  } mid_op_t;

  typedef struct packed {
    logic z;
    logic dc; // nibble_borrow_flag
    logic c;
  } mid_flags_t;

  typedef struct packed {
    logic [DW-1:0] res;
    mid_flags_t    flg;
    mid_flags_t    upd;
  } mid_alu_out_t;

  // decode of one word; masked compares leave don't-care bits out
  function automatic mid_op_t mid_decode(input logic [IW-1:0] w);
    mid_op_t o;
    o = OP_BAD;
    if ((w & NOP_MASK) == NOP_WORD) o = OP_NOP;
    else if (w[13:8] == OPC_REG_MINUS) o = OP_REG_MINUS;
    else if (w[13:8] == OPC_XOR_REG) o = OP_XOR_REG;
    else if (w[13:8] == OPC_SWAP) o = OP_SWAP;
    else if (w[13:8] == OPC_XOR_LIT) o = OP_XOR_LIT;
    else if ((w[13:8] & OPC_LIT_MASK) == OPC_LIT_MINUS) o = OP_LIT_MINUS;
    else if (w[13:10] == OPC_SKIPC) o = OP_SKIPC;
    else if (w[13:11] == OPC_JUMP) o = OP_JUMP;
    return o;
  endfunction

endpackage

// ### hdl/mid_alu.sv
// arithmetic unit: subtract, exclusive or and nibble exchange
`timescale 1ns/1ps
module mid_alu
  import mid_pkg::*;
(
  // decoded operation and operands
  input  wire mid_op_t       op,
  input  wire logic [DW-1:0] opnd,
  input  wire logic [DW-1:0] acc,
  // result with flag values and update mask
  output mid_alu_out_t       result
);

  logic [DW:0] dif;
  logic [4:0]  ldif;

  // one extra bit catches the borrow out of bit 7 and bit 3
  always_comb begin
    result = '0;
    dif    = {1'b0, opnd} - {1'b0, acc};
    ldif   = {1'b0, opnd[3:0]} - {1'b0, acc[3:0]};
    case (op)
      OP_REG_MINUS, OP_LIT_MINUS: begin
        result.res    = dif[DW-1:0];
        result.flg.c  = !dif[DW];
        result.flg.dc = !ldif[4];
        result.upd    = '1;
      end
      OP_XOR_REG, OP_XOR_LIT: begin
        result.res   = opnd ^ acc;
        result.upd.z = 1'b1;
      end
      OP_SWAP: begin
        result.res = {opnd[3:0], opnd[7:4]};
      end
      default: begin
        result.res = '0;
      end
    endcase
    result.flg.z = (result.res == '0);
  end

endmodule // mid_alu

// ### hdl/mid_cyc_timer.sv
// divider that marks the last clock of each instruction cycle
`timescale 1ns/1ps
module mid_cyc_timer
  import mid_pkg::*;
#(
  parameter int N = PH_N
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // run enable and end-of-cycle pulse
  input  wire logic en,
  output logic      tick
);

  localparam int            PW   = $clog2(N);
  localparam logic [PW-1:0] LAST = PW'(N - 1);

  typedef struct packed {
    logic [PW-1:0] ph;
  } mid_tmr_st_t;

  mid_tmr_st_t s_q;
  mid_tmr_st_t s_d;

  // phase restarts when stopped so a new run gets a full first cycle
  always_comb begin
    s_d = s_q;
    if (!en) s_d.ph = '0;
    else if (s_q.ph == LAST) s_d.ph = '0;
    else s_d.ph = s_q.ph + PW'(1);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
  end

  assign tick = en && (s_q.ph == LAST);

  tick_period_a: assert property (@(posedge clock) disable iff (sys_rst || !en)
    tick |=> (!tick)[*3] ##1 tick)
    else $error("instruction cycle is not four clocks");

endmodule // mid_cyc_timer

// ### hdl/mid_core.sv
// instruction core with apb access to program, file registers and state
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module mid_core
  import mid_pkg::*;
#(
  parameter int PD = 64 // program words held in the core
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // apb request
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  // apb answer
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr
);

  localparam int PAW = $clog2(PD);

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                   run;
    logic                   bub;
    logic [PCW-1:0]         pc;
    logic [IW-1:0]          ir;
    logic [DW-1:0]          acc;
    mid_flags_t             flg;
    logic [15:0]            icnt;
    logic [PD-1:0][IW-1:0]  pm;
    logic [FN-1:0][DW-1:0]  rf;
    logic                   rdy;
    logic                   err;
    logic [31:0]            rdata;
  } mid_core_st_t;

  mid_core_st_t s_q;
  mid_core_st_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // decode of the word under execution

  mid_op_t        op;
  logic [FAW-1:0] fi;
  logic           dsel;
  logic [2:0]     bsel;
  logic [7:0]     k8;
  logic [10:0]    k11;
  logic [DW-1:0]  fv;
  logic [DW-1:0]  opnd;
  logic [IW-1:0]  fetch_w;
  mid_alu_out_t   au;
  logic           tick;
  logic           exe;
  logic           taken;

  // operand fields sit at fixed places in the word
  assign op      = mid_decode(s_q.ir);
  assign fi      = s_q.ir[F_LO +: FAW];
  assign dsel    = s_q.ir[D_POS];
  assign bsel    = s_q.ir[B_LO +: 3];
  assign k8      = s_q.ir[K_LO +: 8];
  assign k11     = s_q.ir[K_LO +: PCW];
  assign fv      = s_q.rf[fi];
  assign fetch_w = s_q.pm[s_q.pc[PAW-1:0]];

  // literal ops take k, byte ops the addressed register
  assign opnd = (op == OP_LIT_MINUS || op == OP_XOR_LIT) ? k8 : fv;

  // execution happens on the last clock of each four-clock cycle
  assign exe   = tick;
  assign taken = exe && (op == OP_JUMP || (op == OP_SKIPC && !fv[bsel]));

  mid_alu u_alu (
    .op     (op),
    .opnd   (opnd),
    .acc    (s_q.acc),
    .result (au)
  );

  mid_cyc_timer #(
    .N (PH_N)
  ) u_tmr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .en      (s_q.run),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic          acc_ph;
  logic          wr_now;
  logic          hit;
  logic [31:0]   rd_val;
  logic          in_pm;
  logic          in_rf;

  assign acc_ph = psel && penable;
  assign wr_now = acc_ph && s_q.rdy && pwrite;
  assign in_pm  = ((paddr & WIN_MASK) == PMEM_BASE) && (32'(paddr[9:2]) < PD);
  assign in_rf  = ((paddr & WIN_MASK) == FILE_BASE) && (32'(paddr[9:2]) < FN);

  // read mux; narrow registers sit in the low bits
  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    if (in_pm) begin
      rd_val = 32'(s_q.pm[paddr[2 +: PAW]]);
    end else if (in_rf) begin
      rd_val = 32'(s_q.rf[paddr[2 +: FAW]]);
    end else begin
      case (paddr)
        ADDR_CTRL: rd_val[CTRL_RUN] = s_q.run;
        ADDR_STAT: begin
          rd_val[STAT_Z:STAT_C] = s_q.flg;
          rd_val[STAT_BUB]      = s_q.bub;
          rd_val[STAT_RUN]      = s_q.run;
        end
        ADDR_ACC:  rd_val = 32'(s_q.acc);
        ADDR_PC:   rd_val = 32'(s_q.pc);
        ADDR_ICNT: rd_val = 32'(s_q.icnt);
        default:   hit = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d     = s_q;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;

    // one wait state keeps pready and prdata straight from flops
    if (acc_ph && !s_q.rdy) begin
      s_d.rdy   = 1'b1;
      s_d.err   = !hit;
      s_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
    end

    // writes land only on the edge where pready is sampled high
    if (wr_now && hit) begin
      if (in_pm) begin
        s_d.pm[paddr[2 +: PAW]] = pwdata[IW-1:0];
      end else if (in_rf) begin
        s_d.rf[paddr[2 +: FAW]] = pwdata[DW-1:0];
      end else begin
        case (paddr)
          ADDR_CTRL: begin
            s_d.run = pwdata[CTRL_RUN];
            if (pwdata[CTRL_RESTART]) begin
              s_d.pc  = RST_PC;
              s_d.ir  = NOP_WORD;
              s_d.bub = 1'b0;
            end
          end
          ADDR_STAT: s_d.flg = pwdata[STAT_Z:STAT_C];
          ADDR_ACC:  s_d.acc = pwdata[DW-1:0];
          ADDR_PC:   s_d.pc  = pwdata[PCW-1:0];
          default:   s_d.icnt = s_q.icnt; // counter is read only
        endcase
      end
    end

    // core step comes last so it wins over a software write
    if (exe) begin
      s_d.icnt = s_q.icnt + 16'h0001;
      s_d.ir   = fetch_w;
      s_d.pc   = s_q.pc + 11'h001;
      s_d.bub  = 1'b0;
      s_d.flg  = (au.flg & au.upd) | (s_q.flg & ~au.upd);
      case (op)
        OP_REG_MINUS, OP_XOR_REG, OP_SWAP: begin
          if (dsel) s_d.rf[fi] = au.res;
          else s_d.acc = au.res;
        end
        OP_LIT_MINUS, OP_XOR_LIT: begin
          s_d.acc = au.res;
        end
        OP_SKIPC: begin
          // a clear bit skips: the prefetched word is dropped
          if (!fv[bsel]) begin
            s_d.ir  = NOP_WORD;
            s_d.bub = 1'b1;
          end
        end
        OP_JUMP: begin
          s_d.pc  = k11;
          s_d.ir  = NOP_WORD;
          s_d.bub = 1'b1;
        end
        default: begin
          s_d.bub = 1'b0; // nop and unknown words only advance
        end
      endcase
    end
  end

  // memories clear on reset too; costs area, avoids x in simulation
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.acc <= RST_ACC;
      s_q.pc  <= RST_PC;
      s_q.ir  <= NOP_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  // answer straight from flops
  assign prdata  = s_q.rdata;
  assign pready  = s_q.rdy;
  assign pslverr = s_q.err;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic [DW-1:0] chk_val;
  logic          chk_c;
  logic          chk_dc;
  logic [DW-1:0] xor_ref;
  logic [DW-1:0] swp_ref;
  logic [DW-1:0] ref_res;
  logic          quiet;

  // independent reference values for the arithmetic
  assign chk_val = opnd - s_q.acc;
  assign chk_c   = opnd >= s_q.acc;
  assign chk_dc  = opnd[3:0] >= s_q.acc[3:0];
  assign xor_ref = opnd ^ s_q.acc;
  assign swp_ref = {fv[3:0], fv[7:4]};
  assign ref_res = (op == OP_SWAP) ? swp_ref : (op == OP_XOR_REG) ? xor_ref : chk_val;
  assign quiet   = exe && !wr_now;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence taken_s;
    quiet && taken;
  endsequence

  sequence bubble_s;
    (!exe)[*3] ##1 exe;
  endsequence

  dest_acc_a: assert property (
    quiet && !dsel && (op == OP_REG_MINUS || op == OP_XOR_REG || op == OP_SWAP)
    |=> s_q.acc == $past(ref_res))
    else $error("byte result with target zero missed accumulator");

  dest_reg_a: assert property (
    quiet && dsel && op == OP_XOR_REG
    |=> s_q.rf[$past(fi)] == $past(xor_ref) && s_q.acc == $past(s_q.acc))
    else $error("byte result with target one missed register");

  lit_sub_a: assert property (
    quiet && op == OP_LIT_MINUS
    |=> s_q.acc == $past(chk_val) && s_q.flg.c == $past(chk_c)
        && s_q.flg.dc == $past(chk_dc) && s_q.flg.z == ($past(chk_val) == 8'h00))
    else $error("literal subtract result or borrow wrong");

  reg_sub_a: assert property (
    quiet && op == OP_REG_MINUS
    |=> s_q.flg.z == ($past(chk_val) == 8'h00) && s_q.flg.c == $past(chk_c))
    else $error("register subtract flags wrong");

  xor_flags_a: assert property (
    quiet && op == OP_XOR_LIT
    |=> s_q.acc == $past(xor_ref) && s_q.flg.c == $past(s_q.flg.c)
        && s_q.flg.dc == $past(s_q.flg.dc))
    else $error("literal xor touched borrow flags");

  swap_keep_a: assert property (
    quiet && op == OP_SWAP && !dsel
    |=> s_q.acc == $past(swp_ref) && $stable(s_q.flg))
    else $error("nibble exchange wrong or flags changed");

  bubble_nop_a: assert property (
    taken_s ##1 bubble_s |-> s_q.bub && op == OP_NOP)
    else $error("second cycle did not run as a nop");

  jump_pc_a: assert property (
    quiet && op == OP_JUMP |=> s_q.pc == $past(k11) && s_q.bub)
    else $error("jump did not load counter and bubble");

  fetch_word_a: assert property (
    quiet && !taken |=> s_q.ir == $past(fetch_w) && !s_q.bub)
    else $error("prefetched word not taken whole");

  dont_care_a: assert property (
    mid_decode(s_q.ir ^ X_NOP) == op
    && (op != OP_LIT_MINUS || mid_decode(s_q.ir ^ X_LIT) == op))
    else $error("don't-care bit changed the decode");

endmodule // mid_core

// ### tb/mid_tb.sv
// self-checking bench for the instruction core, driven over apb
`timescale 1ns/1ps
module tb_top
  import mid_pkg::*;
;
  // apb side and bookkeeping
  logic          clock;
  logic          sys_rst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [31:0]   rd;
  logic          err;
  int            mismatches;
  int            check_count;

  // skip at 6 hides word 7, jump at 10 must drop word 11
  localparam logic [IW-1:0] PROG [12] = '{14'h3d35, 14'h3aa5, 14'h0284, 14'h0683,
    14'h0e05, 14'h1805, 14'h1885, 14'h3aff, 14'h0206, 14'h0060, 14'h280a, 14'h3a55};

  mid_core #(.PD(16)) dut (
    .clock   (clock),
    .sys_rst (sys_rst),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  // verdict, printed once from here only
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one transfer, led by an idle edge
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) chk(32'h0000_0000, 32'h0000_0001, "no pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0000, "slave error");
    chk(rd, exp, what);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // hang guard, far past the test length
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    sys_rst     = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    mismatches  = 0;
    check_count = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;

    // state after reset
    rchk(ADDR_ACC, 32'h0000_0000, "acc reset");
    rchk(ADDR_STAT, 32'h0000_0000, "stat reset");
    rchk(ADDR_ICNT, 32'h0000_0000, "count reset");

    // unmapped places answer with an error and zero data
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001, "hole error");
    chk(rd, 32'h0000_0000, "hole data");
    apb(1'b0, PMEM_BASE + 12'h040, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001, "program index error");

    // nops only: stop lands 44 clocks after start, eleven cycles
    wr(ADDR_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clock);
    wr(ADDR_CTRL, 32'h0000_0000);
    rchk(ADDR_ICNT, 32'h0000_000b, "cycle count");

    // load program and operands
    foreach (PROG[i]) wr(PMEM_BASE + 12'(4 * i), {18'h0_0000, PROG[i]});
    wr(ADDR_ACC, 32'h0000_0035);
    wr(FILE_BASE + 12'h00c, 32'h0000_005a);
    wr(FILE_BASE + 12'h010, 32'h0000_0010);
    wr(FILE_BASE + 12'h014, 32'h0000_0001);
    wr(FILE_BASE + 12'h018, 32'h0000_0008);
    wr(FILE_BASE + 12'h1fc, 32'h0000_00c3);
    wr(ADDR_CTRL, 32'h0000_0003);

    // wait for the final jump loop
    n = 0;
    do begin
      apb(1'b0, ADDR_ICNT, 32'h0000_0000);
      n++;
    end while (rd < 32'h0000_001e && n < 100);
    if (rd < 32'h0000_001e) chk(rd, 32'h0000_001e, "settle");
    wr(ADDR_CTRL, 32'h0000_0000);

    // results of subtracts, xor, exchange, skip and jump
    rchk(ADDR_ACC, 32'h0000_00f8, "acc final");
    rchk(ADDR_STAT, 32'h0000_0002, "flags final");
    rchk(FILE_BASE + 12'h00c, 32'h0000_00ff, "xor to reg");
    rchk(FILE_BASE + 12'h010, 32'h0000_006b, "sub to reg");
    rchk(FILE_BASE + 12'h014, 32'h0000_0001, "exchange source kept");
    rchk(FILE_BASE + 12'h1fc, 32'h0000_00c3, "top entry");
    rchk(ADDR_CTRL, 32'h0000_0000, "stopped");
    tally_and_finish();
  end
endmodule // tb_top
